// >>> hdl/nx_exec_pkg.sv
// Purpose: Shared constants for the nibble exchange / direction load / literal xor executor
// Assumes: 14-bit instruction words, 8-bit data path, four phases per instruction cycle
// Notes:   Functional notes follow
// Functional notes
// - Nibble exchange puts bits 3:0 of the file register into 7:4, and 7:4 into 3:0.
// - Destination bit 0 sends the exchanged value to the accumulator, 1 back to the file.
// - Nibble exchange decodes from prefix 00 1110, then d bit and address; no flags change.
// - Direction load copies accumulator into direction register 5 to 7; no flags change.
// - Direction registers are also reached by plain file register reads and writes.
// - Literal xor (prefix 11 1010) xors accumulator with literal, writes it, updates zero only.
package nx_exec_pkg;
  localparam int          INSN_W          = 14;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 7;
  localparam logic [5:0]  OP_NIBBLE_EXCH  = 6'h0E;   // 00 1110
  localparam logic [5:0]  OP_XOR_LIT      = 6'h3A;   // 11 1010
  localparam logic [10:0] OP_LOAD_DIR     = 11'h00C; // 00 0000 0110 0
  localparam int          OPC_HI          = 13;
  localparam int          OPC_LO          = 8;
  localparam int          DEST_BIT        = 7;
  localparam logic [2:0]  DIR_SEL_MIN     = 3'h5;
  localparam logic [2:0]  DIR_SEL_MAX     = 3'h7;
  localparam int          DIR_COUNT       = 3;
  localparam logic [7:0]  DIR_RESET       = 8'hFF;   // Pins come up as inputs
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  // File addresses at which the direction registers also appear
  localparam logic [6:0]  DIR_FILE_BASE   = 7'h05;
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_e;
endpackage

// >>> hdl/nx_dir_regs.sv
// Purpose: Three port direction registers, writable by direction load or by file address
// Assumes: Writes come one at a time: direction load in the write phase, plain file writes at any time
// Notes:   Reads are combinational from the flops
`timescale 1ns/1ps
`default_nettype none
module nx_dir_regs
  import nx_exec_pkg::*;
#(
  parameter int N = DIR_COUNT
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              wr_en,
  input  wire logic [1:0]        wr_idx,
  input  wire logic [7:0]        wr_data,
  input  wire logic [1:0]        rd_idx,
  output logic      [7:0]        rd_data,
  output logic      [N*8-1:0]    all_q
);
  import nx_exec_pkg::*;

  logic [7:0] dir_q [N];

  // Bounded read so an index of 3 gives zero rather than junk
  assign rd_data = (int'(rd_idx) < N) ? dir_q[rd_idx] : 8'h00;

  // Direction store, shared by both write paths
  always_ff @(posedge clock) begin
    for (int i = 0; i < N; i++) begin
      if (!nrst) begin
        dir_q[i] <= DIR_RESET;
      end else if (wr_en && int'(wr_idx) == i) begin
        dir_q[i] <= wr_data;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      all_q[i*8 +: 8] = dir_q[i];
    end
  end
endmodule
`default_nettype wire

// >>> hdl/nx_exec.sv
// Purpose: Executes nibble exchange, direction load and literal xor over four phases
// Assumes: INSN_VALID held for the whole cycle; file data stable from the read phase
// Notes:   Other opcodes are ignored; the rest of the core owns them
`timescale 1ns/1ps
`default_nettype none
module nx_exec
  import nx_exec_pkg::*;
(
  input  wire logic                       CLOCK,
  input  wire logic                       NRST,
  input  wire logic                       INSN_VALID,
  input  wire logic [nx_exec_pkg::INSN_W-1:0] INSN,
  input  wire logic [7:0]                 FILE_RDATA,
  output logic      [6:0]                 FILE_ADDR,
  output logic                            FILE_WE,
  output logic      [7:0]                 FILE_WDATA,
  input  wire logic                       FILE_WR_EXT,
  input  wire logic [6:0]                 FILE_WR_ADDR,
  input  wire logic [7:0]                 FILE_WR_DATA,
  output logic      [7:0]                 DIR_RDATA,
  output logic      [7:0]                 ACC,
  output logic                            ZERO,
  output logic      [23:0]                DIR_ALL,
  output logic      [1:0]                 PHASE,
  output logic                            DONE
);
  import nx_exec_pkg::*;

  phase_e     ph_q, ph_d;
  logic [13:0] insn_q;
  logic [7:0] opnd_q, res_q, acc_q;
  logic       zero_q, done_q;
  logic       is_nx, is_xl, is_ld, sel_ok, d_bit;
  logic [2:0] sel;

  // Field decode of the latched word
  assign is_nx  = insn_q[OPC_HI:OPC_LO] == OP_NIBBLE_EXCH;
  assign is_xl  = insn_q[OPC_HI:OPC_LO] == OP_XOR_LIT;
  assign is_ld  = insn_q[OPC_HI:3] == OP_LOAD_DIR;
  assign sel    = insn_q[2:0];
  assign sel_ok = sel >= DIR_SEL_MIN && sel <= DIR_SEL_MAX;
  assign d_bit  = insn_q[DEST_BIT];

  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  function automatic logic [1:0] dir_index(input logic [2:0] s);
    return 2'(s - DIR_SEL_MIN);
  endfunction

  // Direction window test, shared by the read and the write address paths
  function automatic logic in_dir_window(input logic [6:0] addr);
    return addr >= DIR_FILE_BASE && 7'(addr - DIR_FILE_BASE) < 7'(DIR_COUNT);
  endfunction

  // Phase sequencer runs free: one word per four clocks
  always_comb begin
    case (ph_q)
      PH_DECODE:  ph_d = PH_READ;
      PH_READ:    ph_d = PH_PROCESS;
      PH_PROCESS: ph_d = PH_WRITE;
      default:    ph_d = PH_DECODE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ph_q <= PH_DECODE;
    end else begin
      ph_q <= ph_d;
    end
  end

  // Latch instruction at decode; a bubble becomes all-zero (no-op)
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      insn_q <= 14'h0000;
    end else if (ph_q == PH_DECODE) begin
      insn_q <= INSN_VALID ? INSN : 14'h0000;
    end
  end

  // Operand read: file register or literal
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      opnd_q <= 8'h00;
    end else if (ph_q == PH_READ) begin
      opnd_q <= is_xl ? insn_q[7:0] : FILE_RDATA;
    end
  end

  // Process
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      res_q <= 8'h00;
    end else if (ph_q == PH_PROCESS) begin
      res_q <= is_nx ? swap_nib(opnd_q) : (is_xl ? acc_q ^ opnd_q : acc_q);
    end
  end

  logic wr_acc, wr_file, wr_dir_ld, wr_dir_file, dir_we, in_dir_win;
  logic [1:0] dir_widx;
  logic [6:0] ext_off;
  // Write strobes, write phase only except the ungated plain file write; each one names a single destination
  assign wr_acc    = ph_q == PH_WRITE && ((is_nx && !d_bit) || is_xl);
  assign wr_file   = ph_q == PH_WRITE && is_nx && d_bit;
  assign wr_dir_ld = ph_q == PH_WRITE && is_ld && sel_ok;
  assign ext_off   = FILE_WR_ADDR - DIR_FILE_BASE;
  assign in_dir_win = in_dir_window(FILE_WR_ADDR);
  assign wr_dir_file = FILE_WR_EXT && in_dir_win;
  assign dir_we    = wr_dir_ld || wr_dir_file;
  // The instruction path wins if both hit in one cycle; software should not overlap them
  assign dir_widx  = wr_dir_ld ? dir_index(sel) : ext_off[1:0];

  logic       rd_in_win;
  logic [6:0] rd_off;
  logic [1:0] dir_ridx;
  logic [7:0] dir_wdata;
  // Addresses outside the window park the index on the spare slot, which reads zero;
  // without this, high addresses would alias onto the direction registers
  assign rd_off    = FILE_ADDR - DIR_FILE_BASE;
  assign rd_in_win = in_dir_window(FILE_ADDR);
  assign dir_ridx  = rd_in_win ? rd_off[1:0] : 2'h3;
  assign dir_wdata = wr_dir_ld ? acc_q : FILE_WR_DATA;

  // Accumulator and zero flag; nibble exchange and direction load leave flags alone
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      acc_q  <= ACC_RESET;
      zero_q <= 1'b0;
    end else if (wr_acc) begin
      acc_q <= res_q;
      if (is_xl) begin
        zero_q <= res_q == 8'h00;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= ph_q == PH_WRITE && (is_nx || is_xl || (is_ld && sel_ok));
    end
  end

  // Direction registers; readable at the same file window
  nx_dir_regs #(.N(DIR_COUNT)) u_dir (
    .clock   (CLOCK),
    .nrst    (NRST),
    .wr_en   (dir_we),
    .wr_idx  (dir_widx),
    .wr_data (dir_wdata),
    .rd_idx  (dir_ridx),
    .rd_data (DIR_RDATA),
    .all_q   (DIR_ALL)
  );

  assign FILE_ADDR  = insn_q[6:0];
  assign FILE_WE    = wr_file;
  assign FILE_WDATA = res_q;
  assign ACC        = acc_q;
  assign ZERO       = zero_q;
  assign PHASE      = ph_q;
  assign DONE       = done_q;

  // Checks on the destinations the write phase may touch, plus the phase order
  a_swap_acc: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_q == PH_WRITE && is_nx && !d_bit |=> acc_q == swap_nib($past(opnd_q, 2)))
    else $error("nibble exchange result wrong in accumulator");
  a_swap_file: assert property (@(posedge CLOCK) disable iff (!NRST)
    FILE_WE |-> is_nx && d_bit && FILE_WDATA == {opnd_q[3:0], opnd_q[7:4]})
    else $error("file write without destination bit set");
  a_swap_flags: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_q == PH_WRITE && (is_nx || is_ld) |=> $stable(zero_q))
    else $error("zero flag moved on flagless instruction");
  a_dir_load: assert property (@(posedge CLOCK) disable iff (!NRST)
    wr_dir_ld && !wr_dir_file |=> DIR_ALL[dir_index(sel)*8 +: 8] == $past(acc_q))
    else $error("direction load did not copy accumulator");
  a_dir_file: assert property (@(posedge CLOCK) disable iff (!NRST)
    wr_dir_file && !wr_dir_ld |=> DIR_ALL[$past(ext_off[1:0])*8 +: 8] == $past(FILE_WR_DATA))
    else $error("direction file write lost");
  a_xor_value: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_q == PH_READ && is_xl |=> ##2 acc_q == ($past(acc_q, 3) ^ $past(insn_q[7:0], 3)))
    else $error("literal xor result wrong");
  a_xor_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
    wr_acc && is_xl |=> zero_q == (acc_q == 8'h00))
    else $error("zero flag does not follow xor result");
  a_phase_cycle: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_q == PH_DECODE |=> ph_q == PH_READ ##1 ph_q == PH_PROCESS ##1 ph_q == PH_WRITE)
    else $error("phase order broken");

  // Direction register checks: refused operands, write priority, read window
  a_dir_refused: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_q == PH_WRITE && is_ld && !sel_ok && !wr_dir_file |=> $stable(DIR_ALL))
    else $error("refused direction load changed a register");
  a_dir_priority: assert property (@(posedge CLOCK) disable iff (!NRST)
    wr_dir_ld && wr_dir_file |=> DIR_ALL[dir_index(sel)*8 +: 8] == $past(acc_q))
    else $error("plain write beat the direction load");
  a_dir_read: assert property (@(posedge CLOCK) disable iff (!NRST)
    DIR_RDATA == (in_dir_window(FILE_ADDR) ?
      DIR_ALL[2'(FILE_ADDR - DIR_FILE_BASE)*8 +: 8] : 8'h00))
    else $error("direction read data wrong for file address");

  // Accumulator must only move for the two instructions that target it
  a_acc_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_q == PH_WRITE && !is_nx && !is_xl |=> $stable(acc_q))
    else $error("accumulator moved on a non-writing instruction");

  // Timing checks: strobes stand one cycle and bubbles stay silent
  a_done_phase: assert property (@(posedge CLOCK) disable iff (!NRST)
    DONE |-> $past(ph_q) == PH_WRITE)
    else $error("done outside the cycle after the write phase");
  a_we_pulse: assert property (@(posedge CLOCK) disable iff (!NRST)
    FILE_WE |=> !FILE_WE)
    else $error("file write strobe held too long");
  a_bubble_quiet: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_q == PH_DECODE && !INSN_VALID |=> ##3 !DONE)
    else $error("bubble cycle reported done");

  // Main scenarios
  c_swap_w: cover property (@(posedge CLOCK) disable iff (!NRST) wr_acc && is_nx);
  c_swap_f: cover property (@(posedge CLOCK) disable iff (!NRST) wr_file);
  c_xor_z:  cover property (@(posedge CLOCK) disable iff (!NRST) wr_acc && is_xl && res_q == 8'h00);
  c_dirld:  cover property (@(posedge CLOCK) disable iff (!NRST) wr_dir_ld);
  c_refuse: cover property (@(posedge CLOCK) disable iff (!NRST) ph_q == PH_WRITE && is_ld && !sel_ok);
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the nibble exchange / direction load / literal xor executor
// Assumes: Inputs change on the falling edge; one instruction per four clocks
// Notes:   Expected values are worked out here, never read back from the design
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nx_exec_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        insn_valid = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [7:0]  file_rdata = 8'h00;
  logic        file_wr_ext = 1'b0;
  logic [6:0]  file_wr_addr = 7'h00;
  logic [7:0]  file_wr_data = 8'h00;
  logic [6:0]  file_addr, ad3;
  logic        file_we, zero, done, we3;
  logic [7:0]  file_wdata, dir_rdata, acc, wd3, dr3, a;
  logic [23:0] dir_all, ed;
  logic [1:0]  phase;
  int          err_count = 0;
  int          n_tests = 0;
  nx_exec dut_u (.CLOCK(clock), .NRST(nrst), .INSN_VALID(insn_valid), .INSN(insn),
    .FILE_RDATA(file_rdata), .FILE_ADDR(file_addr), .FILE_WE(file_we),
    .FILE_WDATA(file_wdata), .FILE_WR_EXT(file_wr_ext), .FILE_WR_ADDR(file_wr_addr),
    .FILE_WR_DATA(file_wr_data), .DIR_RDATA(dir_rdata), .ACC(acc), .ZERO(zero),
    .DIR_ALL(dir_all), .PHASE(phase), .DONE(done));
  // 25 MHz core clock
  always #20 clock = ~clock;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("tests=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One instruction cycle; write-phase outputs are captured for the caller
  task automatic run(input logic [13:0] w, input logic [7:0] rd, input logic want_done);
    insn_valid = 1'b1;
    insn = w;
    file_rdata = rd;
    check(24'(phase), 24'h0);
    repeat (3) @(negedge clock);
    we3 = file_we;
    wd3 = file_wdata;
    ad3 = file_addr;
    dr3 = dir_rdata;
    check(24'(phase), 24'h3);
    @(negedge clock);
    check(24'(done), 24'(want_done));
  endtask
  // Xor walks the accumulator to zero so the flag can be seen to stay clear and then set
  task automatic test_xor();
    run({OP_XOR_LIT, 8'hB5}, 8'h00, 1'b1);
    check({acc, 7'h0, zero}, {8'hB5, 8'h0});
    run({OP_XOR_LIT, 8'hAF}, 8'h00, 1'b1);
    check({acc, 7'h0, zero}, {8'h1A, 8'h0});
    run({OP_XOR_LIT, 8'h1A}, 8'h00, 1'b1);
    check({acc, 7'h0, zero}, {8'h00, 8'h1});
    $display("test_xor done");
  endtask
  // Zero flag is set on entry: a nonzero swap result must not clear it
  task automatic test_swap();
    run({OP_NIBBLE_EXCH, 1'b0, 7'h23}, 8'h5A, 1'b1);
    check({acc, 7'h0, zero, 1'b0, ad3}, {8'hA5, 8'h1, 8'h23});
    check(24'(we3), 24'h0);
    check(24'(dr3), 24'h0);
    run({OP_NIBBLE_EXCH, 1'b1, 7'h7F}, 8'h3C, 1'b1);
    check({we3, wd3, 1'b0, ad3}, {1'b1, 8'hC3, 8'h7F});
    check({acc, 7'h0, zero}, {8'hA5, 8'h1});
    $display("test_swap done");
  endtask
  // Every operand 0..7, refused ones must leave the registers alone
  task automatic test_dir();
    a = 8'hA5;
    ed = 24'hFF_FFFF;
    for (int s = 0; s < 8; s++) begin
      a = a ^ 8'(s + 1);
      run({OP_XOR_LIT, 8'(s + 1)}, 8'h00, 1'b1);
      run({OP_LOAD_DIR, 3'(s)}, 8'h00, s >= 5);
      if (s >= 5) ed[8*(s-5) +: 8] = a;
      check(dir_all, ed);
      check({acc, 7'h0, zero}, {a, 7'h0, a == 8'h00});
    end
    run(14'h3FFF, 8'h00, 1'b0);
    check({acc, 16'h0}, {a, 16'h0});
    $display("test_dir done");
  endtask
  // Plain file writes reach the direction registers, reads come back on DIR_RDATA
  task automatic test_ext();
    insn_valid = 1'b0;
    for (int i = 0; i < 4; i++) begin
      file_wr_ext = i < 3;
      file_wr_addr = 7'(5 + i);
      file_wr_data = 8'(8'h11 * (i + 1));
      @(negedge clock);
    end
    check(dir_all, 24'h33_2211);
    run({OP_NIBBLE_EXCH, 1'b0, 7'h06}, 8'h12, 1'b1);
    check({dr3, acc, 8'h0}, {8'h22, 8'h21, 8'h0});
    // A plain write to the same register during a direction load loses to it
    file_wr_ext = 1'b1;
    file_wr_addr = 7'h05;
    file_wr_data = 8'h77;
    run({OP_LOAD_DIR, 3'h5}, 8'h00, 1'b1);
    file_wr_ext = 1'b0;
    check(24'(dir_all[7:0]), 24'h21);
    $display("test_ext done");
  endtask
  // Watchdog: the whole run needs well under 200 clocks
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge clock);
    check({acc, 7'h0, zero, 6'h0, done, file_we}, 24'h0);
    check(dir_all, 24'hFF_FFFF);
    nrst = 1'b1;
    test_xor();
    test_swap();
    test_dir();
    test_ext();
    conclude();
  end
endmodule
`default_nettype wire
